// file: hdl/fsh_consts.vh
// Constants for the fault supervision and heating control block.
`ifndef FSH_CONSTS_VH
`define FSH_CONSTS_VH

// Register byte offsets.
`define FSH_REG_CTRL      8'h00
`define FSH_REG_AVG       8'h04
`define FSH_REG_THRESH    8'h08
`define FSH_REG_LOW       8'h0c
`define FSH_REG_HIGH      8'h10
`define FSH_REG_STATUS    8'h14
`define FSH_REG_SUPPLY    8'h18
`define FSH_REG_VERSION   8'h1c
`define FSH_REG_CMD       8'h20

// Control, command and supply register fields.
`define FSH_CTRL_MODE_LSB 0
`define FSH_CTRL_MODE_MSB 2
`define FSH_CTRL_ERRSEL   3
`define FSH_CTRL_AOUT_EN  4
`define FSH_CTRL_TELE_EN  5
`define FSH_CMD_DUMP      0
`define FSH_SUPPLY_NOSUP  16

// Status byte fields.
`define FSH_ST_ERROR      0
`define FSH_ST_CRIT       6
`define FSH_ST_HEAT       7

// Reset values.
`define FSH_RST_CTRL      6'h01
`define FSH_RST_AVG       16'h000a
`define FSH_RST_THRESH    16'h0000
`define FSH_RST_LOW       16'h0000
`define FSH_RST_HIGH      16'h0032

// Heating modes.
`define FSH_MODE_OFF      3'h0
`define FSH_MODE_VIRT     3'h1
`define FSH_MODE_RAMP     3'h2
`define FSH_MODE_STD      3'h3
`define FSH_MODE_COLD     3'h4
`define FSH_MODE_HOUSING  3'h5
`define FSH_MODE_FULL     3'h6

// Timing: clock rate and times in their own units, and the dump length in words.
`define FSH_CLK_KHZ       100000
`define FSH_TICK_MS       1000
`define FSH_STALE_S       10
`define FSH_AVG_SPLIT_S   10
`define FSH_CRIT_S        10
`define FSH_ARM_MIN_S     10
`define FSH_XDCR_HOLD_S   3600
`define FSH_RAMP_S        125
`define FSH_DUMP_WORDS    5

// Temperature limits in tenths of a degree Celsius.
`define FSH_T_P2          16'sd20
`define FSH_T_P5          16'sd50
`define FSH_T_P7          16'sd70
`define FSH_T_P8          16'sd80
`define FSH_T_P10         16'sd100
`define FSH_T_P15         16'sd150
`define FSH_T_P25         16'sd250
`define FSH_T_M5          -16'sd50
`define FSH_T_M15         -16'sd150
`define FSH_T_M20         -16'sd200
`define FSH_T_M25         -16'sd250

`endif

// file: hdl/fsh_hold.v
// Heater switch with a restartable off-delay measured in seconds.
`timescale 1ns/1ns
`default_nettype none

module fsh_hold #(
	parameter integer HOLD_S = 10
) (
	input  wire i_clk,
	input  wire i_reset,
	input  wire i_clear,
	input  wire i_tick,
	input  wire i_on_cond,
	input  wire i_off_cond,
	output reg  o_heat
);

	reg [11:0] left_q;

	// The delay only runs while the off condition stands; any return of the
	// on condition, or loss of the off condition, reloads it.
	always @(posedge i_clk)
	begin
		if (i_reset || i_clear)
		begin
			o_heat <= 1'b0;
			left_q <= 12'h000;
		end
		else if (i_on_cond || !i_off_cond)
		begin
			if (i_on_cond)
				o_heat <= 1'b1;
			left_q <= HOLD_S[11:0];
		end
		else if (o_heat && i_tick)
		begin
			if (left_q <= 12'h001)
			begin
				o_heat <= 1'b0;
				left_q <= 12'h000;
			end
			else
				left_q <= left_q - 12'h001;
		end
	end

endmodule

`default_nettype wire

// file: hdl/fsh_top.v
// Fault supervision and heater control with its register port.
`timescale 1ns/1ns
`default_nettype none
`include "fsh_consts.vh"

module fsh_top #(
	parameter integer TICK_CYC = `FSH_TICK_MS * `FSH_CLK_KHZ,
	parameter integer HOLD_S   = `FSH_XDCR_HOLD_S,
	parameter [15:0]  AOUT_MIN = 16'h0000,
	parameter [15:0]  AOUT_MAX = 16'hffff,
	// Arbitrary value.
	parameter [31:0]  VERSION  = 32'h0001_0000
) (
	input  wire               i_clk,
	input  wire               i_reset,
	input  wire [7:0]         i_addr,
	input  wire [31:0]        i_wdata,
	input  wire               i_wr,
	input  wire               i_rd,
	output reg  [31:0]        o_rdata,
	input  wire               i_meas_fresh,
	input  wire [15:0]        i_buf_count,
	input  wire signed [15:0] i_virt_temp,
	input  wire signed [15:0] i_base_temp,
	input  wire [15:0]        i_supply_mv,
	input  wire               i_supply_meas_ok,
	input  wire [15:0]        i_analog_in,
	output reg  [15:0]        o_analog_out,
	output reg                o_err_telegram,
	output wire               o_acq_error,
	output wire [7:0]         o_status,
	output reg                o_arm_heat,
	output reg                o_xdcr_heat,
	output reg  [6:0]         o_heat_level,
	output reg                o_dump_valid,
	output reg  [2:0]         o_dump_index,
	output reg  [31:0]        o_dump_data
);

	localparam integer TICK_LAST_I = TICK_CYC - 1;
	localparam integer RAMP_END_I  = `FSH_RAMP_S;
	localparam integer DUMP_LAST_I = `FSH_DUMP_WORDS - 1;
	localparam [26:0] TICK_LAST = TICK_LAST_I[26:0];
	localparam [6:0]  RAMP_END  = RAMP_END_I[6:0];
	localparam [2:0]  DUMP_LAST = DUMP_LAST_I[2:0];

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	reg [5:0]  ctrl_q;
	reg [15:0] avg_q;
	reg [15:0] thresh_q;
	reg [15:0] low_q;
	reg [15:0] high_q;
	reg        dumping_q;

	wire [2:0] mode = ctrl_q[`FSH_CTRL_MODE_MSB:`FSH_CTRL_MODE_LSB];

	// Shared by the read port and the dump stream.
	function [31:0] param_word;
		input [2:0] idx;
		begin
			case (idx)
			3'h0:    param_word = {26'h0, ctrl_q};
			3'h1:    param_word = {16'h0, avg_q};
			3'h2:    param_word = {16'h0, thresh_q};
			3'h3:    param_word = {16'h0, low_q};
			3'h4:    param_word = {16'h0, high_q};
			default: param_word = 32'h0000_0000;
			endcase
		end
	endfunction

	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			ctrl_q   <= `FSH_RST_CTRL;
			avg_q    <= `FSH_RST_AVG;
			thresh_q <= `FSH_RST_THRESH;
			low_q    <= `FSH_RST_LOW;
			high_q   <= `FSH_RST_HIGH;
		end
		else if (i_wr)
		begin
			case (i_addr)
			`FSH_REG_CTRL:   ctrl_q   <= i_wdata[5:0];
			`FSH_REG_AVG:    avg_q    <= i_wdata[15:0];
			`FSH_REG_THRESH: thresh_q <= i_wdata[15:0];
			`FSH_REG_LOW:    low_q    <= i_wdata[15:0];
			`FSH_REG_HIGH:   high_q   <= i_wdata[15:0];
			default:         ;
			endcase
		end
	end

	always @(posedge i_clk)
	begin
		if (i_reset)
			o_rdata <= 32'h0000_0000;
		else if (i_rd)
		begin
			case (i_addr)
			`FSH_REG_CTRL:    o_rdata <= param_word(3'h0);
			`FSH_REG_AVG:     o_rdata <= param_word(3'h1);
			`FSH_REG_THRESH:  o_rdata <= param_word(3'h2);
			`FSH_REG_LOW:     o_rdata <= param_word(3'h3);
			`FSH_REG_HIGH:    o_rdata <= param_word(3'h4);
			`FSH_REG_STATUS:  o_rdata <= {24'h0, o_status};
			// Without a supply measurement the reply is the flag alone.
			`FSH_REG_SUPPLY:  o_rdata <= i_supply_meas_ok ?
				{16'h0, i_supply_mv} : 32'h0001_0000;
			`FSH_REG_VERSION: o_rdata <= VERSION;
			default:          o_rdata <= 32'h0000_0000;
			endcase
		end
		else
			o_rdata <= 32'h0000_0000;
	end

	// ----------------------------------------------------------------
	// Parameter dump
	// ----------------------------------------------------------------
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			dumping_q    <= 1'b0;
			o_dump_valid <= 1'b0;
			o_dump_index <= 3'h0;
			o_dump_data  <= 32'h0000_0000;
		end
		else if (!dumping_q)
		begin
			o_dump_valid <= 1'b0;
			if (i_wr && i_addr == `FSH_REG_CMD && i_wdata[`FSH_CMD_DUMP])
			begin
				dumping_q    <= 1'b1;
				o_dump_index <= 3'h0;
			end
		end
		else
		begin
			o_dump_valid <= 1'b1;
			o_dump_data  <= param_word(o_dump_index);
			o_dump_index <= o_dump_index;
			if (o_dump_valid)
			begin
				o_dump_index <= o_dump_index + 3'h1;
				o_dump_data  <= param_word(o_dump_index + 3'h1);
				if (o_dump_index + 3'h1 == DUMP_LAST)
					dumping_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// One-second tick and acquisition supervision
	// ----------------------------------------------------------------
	reg [26:0] tick_q;
	reg [7:0]  stale_q;
	reg [7:0]  fail_q;
	reg        err_q;
	wire       tick = (tick_q == TICK_LAST);

	wire short_avg = (avg_q < `FSH_AVG_SPLIT_S);
	// The buffer is expected to hold at least half a value per averaged second.
	wire buf_low   = ({i_buf_count, 1'b0} < {1'b0, avg_q});
	wire acq_err   = short_avg ? (stale_q >= `FSH_STALE_S)
	                           : buf_low;
	wire crit      = (fail_q >= `FSH_CRIT_S);

	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			tick_q  <= 27'h0;
			stale_q <= 8'h00;
			fail_q  <= 8'h00;
			err_q   <= 1'b0;
		end
		else
		begin
			tick_q <= tick ? 27'h0 : tick_q + 27'h1;
			err_q  <= acq_err;
			if (i_meas_fresh)
				stale_q <= 8'h00;
			else if (tick && stale_q != 8'hff)
				stale_q <= stale_q + 8'h01;
			// Any cycle without an acquisition error breaks the continuous failure.
			if (!acq_err)
				fail_q <= 8'h00;
			else if (tick && fail_q != 8'hff)
				fail_q <= fail_q + 8'h01;
		end
	end

	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_analog_out   <= 16'h0000;
			o_err_telegram <= 1'b0;
		end
		else
		begin
			if (acq_err && ctrl_q[`FSH_CTRL_AOUT_EN])
				o_analog_out <= ctrl_q[`FSH_CTRL_ERRSEL] ?
					AOUT_MAX : AOUT_MIN;
			else
				o_analog_out <= i_analog_in;
			o_err_telegram <= acq_err && !err_q &&
				ctrl_q[`FSH_CTRL_TELE_EN];
		end
	end

	// ----------------------------------------------------------------
	// Heating conditions
	// ----------------------------------------------------------------
	reg  [1:0] on_c;
	reg  [1:0] off_c;
	wire [1:0] held;
	wire       vt_lt2  = i_virt_temp < `FSH_T_P2;
	wire       bt_lt5  = i_base_temp < `FSH_T_P5;
	wire       arm_on3 = vt_lt2 || bt_lt5;
	wire       arm_off = i_virt_temp > `FSH_T_P7;

	always @*
	begin
		on_c  = 2'b00;
		off_c = 2'b00;
		case (mode)
		`FSH_MODE_VIRT:
		begin
			on_c[0]  = i_virt_temp < $signed(low_q) || acq_err;
			off_c[0] = i_virt_temp > $signed(high_q) && !acq_err;
			on_c[1]  = i_virt_temp < $signed(low_q) || acq_err;
			off_c[1] = i_virt_temp > $signed(low_q) && !acq_err;
		end
		`FSH_MODE_STD:
		begin
			on_c[0]  = arm_on3 ||
				(acq_err && i_base_temp < `FSH_T_P25);
			off_c[0] = arm_off && i_base_temp > `FSH_T_P8 && !crit;
			on_c[1]  = arm_on3 ||
				(acq_err && i_base_temp < `FSH_T_P10);
			off_c[1] = i_virt_temp > `FSH_T_P2 &&
				i_base_temp > `FSH_T_P5 && !crit;
		end
		`FSH_MODE_COLD:
		begin
			on_c[0]  = arm_on3 ||
				(crit && i_base_temp < `FSH_T_P25);
			off_c[0] = arm_off && i_base_temp > `FSH_T_P8 && !crit;
			on_c[1]  = i_virt_temp < `FSH_T_M25 ||
				i_base_temp < `FSH_T_M20 ||
				(crit && i_base_temp < `FSH_T_P5);
			off_c[1] = i_virt_temp > `FSH_T_M20 &&
				i_base_temp > `FSH_T_M15 && !crit;
		end
		`FSH_MODE_HOUSING:
		begin
			on_c[0]  = arm_on3 ||
				(crit && i_base_temp < `FSH_T_P15);
			off_c[0] = arm_off && i_base_temp > `FSH_T_P15 && !crit;
			on_c[1]  = i_virt_temp < `FSH_T_M25 ||
				i_base_temp < `FSH_T_M20 ||
				(crit && i_base_temp < `FSH_T_P15);
			off_c[1] = i_virt_temp > `FSH_T_M20 &&
				i_base_temp > `FSH_T_M5 && !crit;
		end
		default:
		begin
			on_c  = 2'b00;
			off_c = 2'b00;
		end
		endcase
	end

	// Index 0 is the arm heater, index 1 the transducer heater.
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : gen_hold
			fsh_hold #(
				.HOLD_S (g == 0 ? `FSH_ARM_MIN_S : HOLD_S)
			) u_hold (
				.i_clk      (i_clk),
				.i_reset    (i_reset),
				.i_clear    (mode == `FSH_MODE_OFF),
				.i_tick     (tick),
				.i_on_cond  (on_c[g]),
				.i_off_cond (off_c[g]),
				.o_heat     (held[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Heater outputs and soft start
	// ----------------------------------------------------------------
	wire supply_ok = i_supply_meas_ok &&
		(i_supply_mv > thresh_q);
	reg  [1:0] want;
	reg  [6:0] ramp_q;

	always @*
	begin
		case (mode)
		`FSH_MODE_OFF:  want = 2'b00;
		`FSH_MODE_RAMP: want = 2'b11;
		`FSH_MODE_FULL: want = 2'b11;
		3'h7:           want = 2'b00;
		default:        want = held;
		endcase
		if (!supply_ok)
			want = 2'b00;
	end

	// The ramp restarts whenever both heaters go dark, so outside full mode a brown-out
	// re-enters with soft start rather than a full inrush.
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			ramp_q       <= 7'h00;
			o_arm_heat   <= 1'b0;
			o_xdcr_heat  <= 1'b0;
			o_heat_level <= 7'h00;
		end
		else
		begin
			o_arm_heat  <= want[0];
			o_xdcr_heat <= want[1];
			if (want == 2'b00)
				ramp_q <= 7'h00;
			else if (tick && ramp_q != RAMP_END)
				ramp_q <= ramp_q + 7'h01;
			if (want == 2'b00)
				o_heat_level <= 7'h00;
			else if (mode == `FSH_MODE_FULL)
				o_heat_level <= RAMP_END;
			else
				o_heat_level <= ramp_q;
		end
	end

	assign o_acq_error = err_q;
	assign o_status    = {o_arm_heat | o_xdcr_heat,
	                      crit,
	                      5'h00,
	                      err_q};

endmodule

`default_nettype wire

// file: sim/fsh_host_model.sv
// Host side model that collects the error telegrams.
`timescale 1ns/1ns
`default_nettype none
module fsh_host_model (
	input wire logic	i_clk,
	input wire logic	i_err_telegram,
	output var int		o_n_tele
);
	// A telegram is one pulse; a held level would count once per cycle,
	// which is how a stuck line shows up in the bench.
	initial o_n_tele = 0;
	always @(posedge i_clk)
		if (i_err_telegram)
			o_n_tele <= o_n_tele + 1;
endmodule
`default_nettype wire

// file: sim/fsh_top_asserts.sv
// Port-level checker for the fault supervision and heater block.
`timescale 1ns/1ns
`default_nettype none
module fsh_top_chk #(
	parameter integer TICK_CYC = 20
) (
	input wire		i_clk,
	input wire		i_reset,
	input wire [7:0]	i_addr,
	input wire [31:0]	i_wdata,
	input wire		i_wr,
	input wire		i_rd,
	input wire [31:0]	o_rdata,
	input wire		i_meas_fresh,
	input wire [15:0]	i_buf_count,
	input wire [15:0]	i_supply_mv,
	input wire		i_supply_meas_ok,
	input wire [15:0]	i_analog_in,
	input wire [15:0]	o_analog_out,
	input wire		o_err_telegram,
	input wire		o_acq_error,
	input wire [7:0]	o_status,
	input wire		o_arm_heat,
	input wire		o_xdcr_heat,
	input wire [6:0]	o_heat_level
);
	// ----
	// Shadow copies of the control, averaging and threshold settings, the supply gate and the error and stale counters.
	// ----
	reg [5:0]	ctrl_q;
	reg [15:0]	avg_q;
	reg [15:0]	thr_q;
	reg		gate_q;
	integer		err_cnt;
	integer		stale_cnt;

	always @(posedge i_clk)
	begin
		gate_q <= !i_supply_meas_ok || (i_supply_mv <= thr_q);
		if (i_reset)
		begin
			ctrl_q <= 6'h01;
			avg_q <= 16'h000a;
			thr_q <= 16'h0000;
			err_cnt <= 0;
			stale_cnt <= 0;
		end
		else
		begin
			err_cnt <= o_acq_error ? err_cnt + 1 : 0;
			stale_cnt <= i_meas_fresh ? 0 : stale_cnt + 1;
			if (i_wr && i_addr == 8'h00)
				ctrl_q <= i_wdata[5:0];
			if (i_wr && i_addr == 8'h04)
				avg_q <= i_wdata[15:0];
			if (i_wr && i_addr == 8'h08)
				thr_q <= i_wdata[15:0];
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	// The tick phase is free running, so nine full periods is the
	// tightest bound that holds for every alignment.
	property p_stale;
		$rose(o_acq_error) && avg_q < 16'h000a |-> stale_cnt >= 9 * TICK_CYC;
	endproperty
	a_stale: assert property (p_stale) else $error("stale error early");
	property p_half;
		avg_q >= 16'h000a && i_buf_count * 2 < avg_q |=> o_acq_error;
	endproperty
	a_half: assert property (p_half) else $error("buffer error missed");
	property p_force;
		o_acq_error && $past(o_acq_error) && ctrl_q[4] && $past(ctrl_q[4])
			&& ctrl_q[3] == $past(ctrl_q[3])
			|-> o_analog_out == (ctrl_q[3] ? 16'hffff : 16'h0000);
	endproperty
	a_force: assert property (p_force) else $error("analog not forced");
	property p_normal;
		!o_acq_error && !$past(o_acq_error) && !$past(i_reset)
			|-> o_analog_out == $past(i_analog_in);
	endproperty
	a_normal: assert property (p_normal) else $error("analog not normal");
	property p_tele;
		$rose(o_acq_error) && ctrl_q[5] |-> ##[0:1] o_err_telegram;
	endproperty
	a_tele: assert property (p_tele) else $error("no telegram");
	property p_bits;
		o_status[0] == o_acq_error && o_status[7] == (o_arm_heat || o_xdcr_heat);
	endproperty
	a_bits: assert property (p_bits) else $error("status bits wrong");
	property p_crit;
		o_status[6] |-> err_cnt >= 9 * TICK_CYC;
	endproperty
	a_crit: assert property (p_crit) else $error("criterion early");
	property p_off;
		ctrl_q[2:0] == 3'h0 |=> !o_arm_heat && !o_xdcr_heat;
	endproperty
	a_off: assert property (p_off) else $error("heater on in mode 0");
	property p_full;
		ctrl_q[2:0] == 3'h6 && i_supply_meas_ok && i_supply_mv > thr_q
			|=> o_heat_level == 7'h7d;
	endproperty
	a_full: assert property (p_full) else $error("full level missing");
	property p_gate;
		gate_q |-> !o_arm_heat && !o_xdcr_heat;
	endproperty
	a_gate: assert property (p_gate) else $error("heat on low supply");
	property p_supply;
		i_rd && i_addr == 8'h18 |=> o_rdata == ($past(i_supply_meas_ok)
			? {16'h0000, $past(i_supply_mv)} : 32'h0001_0000);
	endproperty
	a_supply: assert property (p_supply) else $error("supply read wrong");

	c_tele: cover property (o_err_telegram);
	c_crit: cover property (o_status[6]);
	c_full: cover property (o_heat_level == 7'h7d);
endmodule

bind fsh_top fsh_top_chk #(.TICK_CYC(TICK_CYC)) i_chk (.*);
`default_nettype wire

// file: sim/fsh_top_tb_top.sv
// Self-checking bench for the fault supervision and heater block.
`timescale 1ns/1ns
`default_nettype none
module fsh_top_tb_top;
	localparam integer TK = 20;
	localparam [31:0] VER = 32'h0005_a5a5; // Arbitrary value.
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_meas_fresh = 1'b0;
	logic [15:0] i_buf_count = 16'h0064;
	logic signed [15:0] i_virt_temp = 16'sh0064;
	logic signed [15:0] i_base_temp = 16'sh0064;
	logic [15:0] i_supply_mv = 16'h2ee0;
	logic i_supply_meas_ok = 1'b1;
	logic [15:0] i_analog_in = 16'h1234;
	wire [31:0] o_rdata;
	wire [15:0] o_analog_out;
	wire o_err_telegram;
	wire o_acq_error;
	wire [7:0] o_status;
	wire o_arm_heat;
	wire o_xdcr_heat;
	wire [6:0] o_heat_level;
	wire o_dump_valid;
	wire [2:0] o_dump_index;
	wire [31:0] o_dump_data;
	int n_tele;
	int failures = 0;
	int n_checks = 0;
	logic [31:0] dw [5] = '{32'h01, 32'h14, 32'h2cec, 32'h0, 32'h32};

	fsh_top #(.TICK_CYC(TK), .HOLD_S(30), .VERSION(VER)) i_dut (.*);
	fsh_host_model i_host (.i_clk(i_clk), .i_err_telegram(o_err_telegram),
		.o_n_tele(n_tele));

	always #5 i_clk = ~i_clk;

	// ----
	// Report, check, wait and access tasks.
	// ----
	task automatic stop_test();
		if (failures == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input [39:0] e, input [39:0] g);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic wr(input [7:0] a, input [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input [7:0] a, input [31:0] e);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk("rdata", e, o_rdata);
	endtask
	task automatic fresh();
		@(posedge i_clk);
		i_meas_fresh <= 1'b1;
		@(posedge i_clk);
		i_meas_fresh <= 1'b0;
	endtask

	initial
	begin
		#200000;
		failures++;
		stop_test();
	end

	initial
	begin
		cyc(6);
		i_reset <= 1'b0;
		rd(8'h00, 32'h01);
		rd(8'h04, 32'h0a);
		rd(8'h10, 32'h32);
		rd(8'h24, 32'h0);
		rd(8'h1c, VER);
		rd(8'h18, 32'h2ee0);
		@(posedge i_clk) i_supply_meas_ok <= 1'b0;
		rd(8'h18, 32'h0001_0000);
		@(posedge i_clk) i_supply_meas_ok <= 1'b1;
		wr(8'h08, 32'h2cec);
		wr(8'h04, 32'h05);
		wr(8'h00, 32'h38);
		fresh();
		cyc(8 * TK);
		#1 chk("err early", 1'h0, o_acq_error);
		cyc(3 * TK + 5);
		#1 chk("err stale", 1'h1, o_acq_error);
		chk("aout max", 16'hffff, o_analog_out);
		chk("status", 8'h01, o_status);
		chk("tele", 1'h1, n_tele);
		cyc(11 * TK);
		#1 chk("crit", 8'h41, o_status);
		chk("mode0", 2'h0, {o_arm_heat, o_xdcr_heat});
		fresh();
		cyc(3);
		#1 chk("err clr", 1'h0, o_acq_error);
		chk("aout", 16'h1234, o_analog_out);
		chk("status clr", 8'h00, o_status);
		wr(8'h00, 32'h10);
		wr(8'h04, 32'h14);
		@(posedge i_clk) i_buf_count <= 16'h0009;
		cyc(3);
		#1 chk("err buf", 1'h1, o_acq_error);
		chk("aout min", 16'h0, o_analog_out);
		chk("tele off", 1'h1, n_tele);
		@(posedge i_clk) i_buf_count <= 16'h000a;
		cyc(3);
		#1 chk("err half", 1'h0, o_acq_error);
		wr(8'h00, 32'h06);
		cyc(2);
		#1 chk("full lvl", 7'h7d, o_heat_level);
		chk("full on", 2'h3, {o_status[7], o_arm_heat});
		@(posedge i_clk) i_supply_mv <= 16'h2af8;
		cyc(2);
		#1 chk("low sup", 3'h0, {o_status[7], o_arm_heat, o_xdcr_heat});
		wr(8'h00, 32'h02);
		@(posedge i_clk) i_supply_mv <= 16'h2ee0;
		cyc(2 * TK);
		#1 chk("ramp lo", 1'h1, o_heat_level < 7'h05);
		chk("ramp on", 1'h1, o_arm_heat);
		cyc(130 * TK);
		#1 chk("ramp top", 7'h7d, o_heat_level);
		wr(8'h00, 32'h01);
		@(posedge i_clk) i_virt_temp <= -16'sh000a;
		cyc(3);
		#1 chk("cold", 2'h3, {o_arm_heat, o_xdcr_heat});
		@(posedge i_clk) i_virt_temp <= 16'sh003c;
		cyc(5 * TK);
		#1 chk("arm min", 2'h3, {o_arm_heat, o_xdcr_heat});
		cyc(8 * TK);
		#1 chk("arm off", 2'h1, {o_arm_heat, o_xdcr_heat});
		@(posedge i_clk) i_virt_temp <= -16'sh000a;
		@(posedge i_clk) i_virt_temp <= 16'sh003c;
		cyc(25 * TK);
		#1 chk("hold", 1'h1, o_xdcr_heat);
		cyc(8 * TK);
		#1 chk("hold end", 1'h0, o_xdcr_heat);
		wr(8'h20, 32'h01);
		cyc(1);
		for (int i = 0; i < 5; i++)
		begin
			#1 chk("dump", {1'b1, 3'(i), dw[i]},
				{o_dump_valid, o_dump_index, o_dump_data});
			@(posedge i_clk);
		end
		#1 chk("dump end", 1'h0, o_dump_valid);
		wr(8'h00, 32'h00);
		wr(8'h00, 32'h03);
		@(posedge i_clk) i_base_temp <= 16'sh001e;
		cyc(3);
		#1 chk("mode3", 2'h3, {o_arm_heat, o_xdcr_heat});
		wr(8'h00, 32'h00);
		wr(8'h00, 32'h04);
		cyc(3);
		#1 chk("mode4", 2'h2, {o_arm_heat, o_xdcr_heat});
		wr(8'h00, 32'h00);
		wr(8'h00, 32'h05);
		@(posedge i_clk) i_base_temp <= -16'sd210;
		cyc(3);
		#1 chk("mode5", 2'h3, {o_arm_heat, o_xdcr_heat});
		stop_test();
	end
endmodule
`default_nettype wire
